// ### bench/tmr_monitor.sv
// Purpose: Port assertions for tmr_top.
// Assumes: Run and type bits change only by bus writes.
// Notes:   Control bits are mirrored from the writes seen.
`timescale 1ns/10ps
`default_nettype none

module tmr_monitor (
  input wire logic                  clk,
  input wire logic                  rstn,
  input wire tmr_pkg::tmr_sfr_req_t sfr_req,
  input wire logic [7:0]            sfr_rdata,
  input wire tmr_pkg::tmr_evt_t     vector_ack,
  input wire tmr_pkg::tmr_evt_t     irq_req,
  input wire logic                  ext_irq_a_pin,
  input wire logic                  ext_irq_b_pin,
  input wire logic                  unit_a_count_pin,
  input wire logic                  unit_b_count_pin
);
  logic [7:0] ctl_q;
  logic       cw;
  logic       ta;
  logic       tb;
  assign cw = sfr_req.wr && sfr_req.addr == 8'h88;
  assign ta = ctl_q[0];
  assign tb = ctl_q[2];
  always_ff @(posedge clk) ctl_q <= !rstn ? 8'h00 : cw ? sfr_req.wdata : ctl_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  sequence s_wr_mode;
    sfr_req.wr && sfr_req.addr == 8'h89;
  endsequence
  sequence s_rd_mode;
    sfr_req.rd && !sfr_req.wr && sfr_req.addr == 8'h89;
  endsequence
  property p_mode_rb;
    s_wr_mode ##1 s_rd_mode |=> sfr_rdata == $past(sfr_req.wdata, 2);
  endproperty
  a_mode_rb: assert property (p_mode_rb) else $error("mode readback");
  property p_unmapped;
    sfr_req.rd && !(sfr_req.addr inside {[8'h88:8'h8D]}) |=> sfr_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_ack_a;
    vector_ack.unit_a && !ctl_q[4] && !cw |=> !irq_req.unit_a;
  endproperty
  a_ack_a: assert property (p_ack_a) else $error("unit a ack");
  property p_ack_b;
    vector_ack.unit_b && !ctl_q[6] && !cw |=> !irq_req.unit_b;
  endproperty
  a_ack_b: assert property (p_ack_b) else $error("unit b ack");
  property p_lvl_a;
    !ta && !$past(ta, 3) |-> irq_req.ext_a == !$past(ext_irq_a_pin, 3);
  endproperty
  a_lvl_a: assert property (p_lvl_a) else $error("level a");
  property p_lvl_b;
    !tb && $fell(ext_irq_b_pin) ##1 !tb [*2] |=> irq_req.ext_b;
  endproperty
  a_lvl_b: assert property (p_lvl_b) else $error("level b");
  property p_edge_a;
    ta && $past(ta, 4) && $fell(ext_irq_a_pin) |-> ##[1:4] irq_req.ext_a;
  endproperty
  a_edge_a: assert property (p_edge_a) else $error("edge a");
  // Pin high four cycles means no edge can race the acknowledge
  property p_ack_xb;
    ext_irq_b_pin [*4] ##0 (tb && $past(tb) && vector_ack.ext_b && !cw) |=> !irq_req.ext_b;
  endproperty
  a_ack_xb: assert property (p_ack_xb) else $error("edge b ack");
endmodule : tmr_monitor

bind tmr_top tmr_monitor u_mon (.clk(clk), .rstn(rstn), .sfr_req(sfr_req),
  .sfr_rdata(sfr_rdata), .vector_ack(vector_ack), .irq_req(irq_req),
  .ext_irq_a_pin(ext_irq_a_pin), .ext_irq_b_pin(ext_irq_b_pin),
  .unit_a_count_pin(unit_a_count_pin), .unit_b_count_pin(unit_b_count_pin));
`default_nettype wire

// ### bench/tmr_pin_model.sv
// Purpose: Far-side driver of a count pin.
// Assumes: Caller asks for whole pulses.
// Notes:   Pin idles high between pulses.
`timescale 1ns/10ps
`default_nettype none

module tmr_pin_model (
  input  wire logic clk,
  output var  logic pin
);
  initial pin = 1'b1;

  // Low lasts 30 clocks and high 31 between pulses, each longer than one 12-clock sample period
  task automatic pulses(input int n);
    repeat (n) begin
      @(negedge clk) pin <= 1'b0;
      repeat (30) @(negedge clk);
      pin <= 1'b1;
      repeat (30) @(negedge clk);
    end
  endtask : pulses
endmodule : tmr_pin_model
`default_nettype wire

// ### bench/tmr_top_bench.sv
// Purpose: Self-checking bench for tmr_top.
// Assumes: Read data is valid one cycle after the strobe.
// Notes:   Stop writes after an overflow keep its flag bit at 1 so it survives.
`timescale 1ns/10ps
`default_nettype none

module tmr_top_bench;
  logic                  clk;
  logic                  rstn;
  tmr_pkg::tmr_sfr_req_t sfr_req;
  logic [7:0]            sfr_rdata;
  tmr_pkg::tmr_evt_t     vector_ack;
  tmr_pkg::tmr_evt_t     irq_req;
  logic                  pin_a;
  logic                  pin_b;
  logic                  cnt_a;
  logic                  cnt_b;
  int                    n_fail;
  int                    cmp_count;
  int                    cyc;

  tmr_top dut (.clk(clk), .rstn(rstn), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .vector_ack(vector_ack), .irq_req(irq_req), .ext_irq_a_pin(pin_a),
    .ext_irq_b_pin(pin_b), .unit_a_count_pin(cnt_a), .unit_b_count_pin(cnt_b));
  tmr_pin_model pm (.clk(clk), .pin(cnt_a));
  tmr_pin_model pmb (.clk(clk), .pin(cnt_b));
  ////////////////////////////////////////
  task automatic test_done;
    if (n_fail == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_req <= '{a, w, r, d};
  endtask : op

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, a, d);
    op(1'b0, 1'b0, a, 8'h00);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    op(1'b0, 1'b1, a, 8'h00);
    op(1'b0, 1'b0, a, 8'h00);
    cmp($sformatf("reg %h", a), e, sfr_rdata);
  endtask : rdc

  task automatic fl(input logic [3:0] e);
    cmp("irq_req", {4'h0, e}, {4'h0, irq_req});
  endtask : fl

  task automatic ack(input logic [3:0] v);
    @(negedge clk);
    vector_ack <= v;
    @(negedge clk);
    vector_ack <= 4'h0;
  endtask : ack

  task automatic wt(input int b);
    for (int i = 0; i < 100 && irq_req[b] !== 1'b1; i++)
      @(negedge clk);
  endtask : wt
  ////////////////////////////////////////
  task automatic t_ovf;
    op(1'b1, 1'b0, 8'h89, 8'h01);
    rdc(8'h89, 8'h01);
    wr(8'h8A, 8'hFF);
    wr(8'h8C, 8'hFF);
    wr(8'h88, 8'h10);
    wt(2);
    wr(8'h88, 8'h20);
    rdc(8'h8A, 8'h00);
    rdc(8'h8C, 8'h00);
    rdc(8'h88, 8'h20);
    ack(4'h4);
    fl(4'h0);
  endtask : t_ovf

  // Run spans exactly 12 edges, so exactly one tick lands inside
  task automatic t_mode0;
    wr(8'h89, 8'h00);
    wr(8'h8A, 8'hFF);
    wr(8'h8C, 8'h00);
    wr(8'h88, 8'h10);
    repeat (10) @(negedge clk);
    wr(8'h88, 8'h00);
    rdc(8'h8A, 8'hE0);
    rdc(8'h8C, 8'h01);
  endtask : t_mode0

  task automatic t_reload;
    wr(8'h89, 8'h20);
    wr(8'h8D, 8'hF0);
    wr(8'h8B, 8'hFE);
    wr(8'h88, 8'h40);
    wt(3);
    wr(8'h88, 8'h80);
    rdc(8'h8B, 8'hF0);
    rdc(8'h8D, 8'hF0);
    ack(4'h8);
    fl(4'h0);
    wr(8'h89, 8'h30);
    wr(8'h88, 8'h40);
    repeat (30) @(negedge clk);
    wr(8'h88, 8'h00);
    rdc(8'h8B, 8'hF0);
  endtask : t_reload

  task automatic t_count;
    wr(8'h89, 8'h05);
    wr(8'h8A, 8'h00);
    wr(8'h88, 8'h10);
    pm.pulses(3);
    wr(8'h88, 8'h00);
    rdc(8'h8A, 8'h03);
    wr(8'h89, 8'h0D);
    pin_a <= 1'b0;
    wr(8'h88, 8'h10);
    pm.pulses(2);
    pin_a <= 1'b1;
    pm.pulses(1);
    wr(8'h88, 8'h00);
    rdc(8'h8A, 8'h04);
  endtask : t_count

  // Gate closed for the first pulse, so only the last two count
  task automatic t_more;
    wr(8'h89, 8'hD0);
    wr(8'h8B, 8'h00);
    pin_b <= 1'b0;
    wr(8'h88, 8'h40);
    pmb.pulses(1);
    pin_b <= 1'b1;
    pmb.pulses(2);
    wr(8'h88, 8'h00);
    rdc(8'h8B, 8'h02);
    wr(8'h89, 8'h33);
    wr(8'h8C, 8'hFE);
    wr(8'h8A, 8'h00);
    wr(8'h88, 8'h40);
    wt(3);
    wr(8'h88, 8'h80);
    rdc(8'h8C, 8'h00);
    rdc(8'h8A, 8'h00);
    rdc(8'h8B, 8'h02);
    ack(4'h8);
    fl(4'h0);
  endtask : t_more

  // Reset after a mode write must return mode, control and unit B high byte to zero
  task automatic t_rst;
    wr(8'h89, 8'h11);
    rstn <= 1'b0;
    repeat (2) @(negedge clk);
    rstn <= 1'b1;
    rdc(8'h89, 8'h00);
    rdc(8'h88, 8'h00);
    rdc(8'h8D, 8'h00);
  endtask : t_rst

  task automatic t_ext;
    pin_b <= 1'b0;
    repeat (5) @(negedge clk);
    fl(4'h2);
    ack(4'h2);
    fl(4'h2);
    pin_b <= 1'b1;
    repeat (5) @(negedge clk);
    fl(4'h0);
    wr(8'h88, 8'h05);
    repeat (4) @(negedge clk);
    pin_a <= 1'b0;
    pin_b <= 1'b0;
    repeat (5) @(negedge clk);
    fl(4'h3);
    pin_a <= 1'b1;
    pin_b <= 1'b1;
    repeat (5) @(negedge clk);
    fl(4'h3);
    ack(4'h3);
    fl(4'h0);
  endtask : t_ext
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    rstn = 1'b0;
    sfr_req = '0;
    vector_ack = '0;
    pin_a = 1'b1;
    pin_b = 1'b1;
    n_fail = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (20) @(negedge clk);
    rstn <= 1'b1;
    for (int a = 8'h88; a <= 8'h8E; a++)
      rdc(8'(a), 8'h00);
    t_ovf;
    t_mode0;
    t_reload;
    t_count;
    t_more;
    t_ext;
    t_rst;
    test_done;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      test_done;
    end
  end
endmodule : tmr_top_bench
`default_nettype wire

// ### logic/tmr_div.sv
// Purpose: Peripheral-cycle tick from the system clock.
// Assumes: One clock domain.
// Notes:   Tick is a registered one-cycle pulse.
`timescale 1ns/10ps
`default_nettype none

module tmr_div (
  input  wire logic clk,
  input  wire logic rstn,
  output var  logic tick
);

  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } tmr_div_st_t;

  tmr_div_st_t st_q;
  tmr_div_st_t st_d;

  always_comb begin
    st_d      = st_q;
    st_d.tick = (st_q.cnt == tmr_pkg::DIV_LAST);
    if (st_d.tick) begin
      st_d.cnt = 4'h0;
    end else begin
      st_d.cnt = st_q.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;

endmodule : tmr_div
`default_nettype wire

// ### logic/tmr_sync.sv
// Purpose: Two-flop synchroniser for asynchronous pins.
// Assumes: Pins may change at any time relative to clk.
// Notes:   Only the second stage leaves this module.
`timescale 1ns/10ps
`default_nettype none

module tmr_sync #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] pin,
  output var  logic [W-1:0] sync
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tmr_sync_st_t;

  tmr_sync_st_t st_q;
  tmr_sync_st_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = pin;
    st_d.s2 = st_q.s1;
  end

  // Reset to all ones: idle pins sit high, so no false edge after reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync = st_q.s2;

endmodule : tmr_sync
`default_nettype wire

// ### logic/tmr_top.sv
// Purpose: Two timer/counter units with external interrupt flag logic.
// Assumes: CPU reaches the registers over the special function register bus.
// Notes:   Read data is registered and valid one clock after the read strobe.
//          Count writes win over counting in the same cycle.
`timescale 1ns/10ps
`default_nettype none

module tmr_top (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire tmr_pkg::tmr_sfr_req_t sfr_req,
  output var  logic [7:0]            sfr_rdata,
  input  wire tmr_pkg::tmr_evt_t     vector_ack,
  output var  tmr_pkg::tmr_evt_t     irq_req,
  input  wire logic                  ext_irq_a_pin,
  input  wire logic                  ext_irq_b_pin,
  input  wire logic                  unit_a_count_pin,
  input  wire logic                  unit_b_count_pin
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // One step of a unit in modes 00..10; mode 11 treats low as a plain byte
  // The ovf field carries the rollover that raises the unit's flag
  function automatic tmr_pkg::tmr_cnt_t step(
    input logic [1:0] mode,
    input logic       inc,
    input logic [7:0] lo,
    input logic [7:0] hi
  );
    tmr_pkg::tmr_cnt_t r;
    logic [5:0]        p;
    logic [8:0]        l;
    logic [8:0]        h;
    r     = '0;
    r.lo  = lo;
    r.hi  = hi;
    p     = {1'b0, lo[tmr_pkg::PRESC_W-1:0]} + 6'h01;
    l     = {1'b0, lo} + 9'h001;
    h     = {1'b0, hi} + 9'h001;
    if (inc) begin
      unique case (mode)
        tmr_pkg::MODE_13BIT: begin
          // Top three low-byte bits above the prescaler are left alone, so software may park data there
          r.lo[tmr_pkg::PRESC_W-1:0] = p[tmr_pkg::PRESC_W-1:0];
          if (p[tmr_pkg::PRESC_W]) begin
            r.hi  = h[7:0];
            r.ovf = h[8];
          end
        end
        tmr_pkg::MODE_16BIT: begin
          r.lo = l[7:0];
          if (l[8]) begin
            r.hi  = h[7:0];
            r.ovf = h[8];
          end
        end
        tmr_pkg::MODE_RELD: begin
          r.lo  = l[8] ? hi : l[7:0];
          r.ovf = l[8];
        end
        tmr_pkg::MODE_SPLIT: begin
          r.lo  = l[7:0];
          r.ovf = l[8];
        end
      endcase
    end
    return r;
  endfunction : step

  // Unit input qualifier: run, gate, and timer or counter source
  // Gating sees the synchronised pin, so it lags the pin by two clocks
  function automatic logic advance(
    input logic [3:0] ctl,
    input logic       run,
    input logic       gate_pin,
    input logic       tick,
    input logic       fall
  );
    logic go;
    go = run && (!ctl[tmr_pkg::GATE] || gate_pin);
    return go && (ctl[tmr_pkg::SRC] ? fall : tick);
  endfunction : advance

  ////////////////////////////////////////////////////////////////////////////
  // State

  // Control, mode and count registers plus pin history and read data
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] a_lo;
    logic [7:0] a_hi;
    logic [7:0] b_lo;
    logic [7:0] b_hi;
    logic       smp_a;
    logic       smp_b;
    logic       prev_xa;
    logic       prev_xb;
    logic [7:0] rdata;
  } tmr_st_t;

  tmr_st_t st_q;
  tmr_st_t st_d;

  logic [3:0] pins_s;
  logic       tick;

  // Every pin crosses into the clock domain here; no logic reads a raw pin
  tmr_sync #(
    .W (4)
  ) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .pin  ({ext_irq_b_pin, ext_irq_a_pin, unit_b_count_pin, unit_a_count_pin}),
    .sync (pins_s)
  );

  // One shared tick keeps both units and pin sampling in step
  tmr_div u_div (
    .clk  (clk),
    .rstn (rstn),
    .tick (tick)
  );

  logic xb_s;
  logic xa_s;
  logic cb_s;
  logic ca_s;

  assign xb_s = pins_s[3];
  assign xa_s = pins_s[2];
  assign cb_s = pins_s[1];
  assign ca_s = pins_s[0];

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic [3:0]        ctl_a;
  logic [3:0]        ctl_b;
  logic [1:0]        md_a;
  logic [1:0]        md_b;
  logic              fall_a;
  logic              fall_b;
  logic              inc_a;
  logic              inc_b;
  logic              inc_ah;
  logic              run_b_own;
  tmr_pkg::tmr_cnt_t nx_a;
  tmr_pkg::tmr_cnt_t nx_b;
  logic [8:0]        ah_sum;
  logic              set_a;
  logic              set_b;
  logic              set_xa;
  logic              set_xb;
  logic              wr_ctrl;

  always_comb begin
    st_d  = st_q;
    ctl_a = st_q.mode[tmr_pkg::A_NIB +: 4];
    ctl_b = st_q.mode[tmr_pkg::B_NIB +: 4];
    md_a  = ctl_a[tmr_pkg::MODE +: 2];
    md_b  = ctl_b[tmr_pkg::MODE +: 2];

    // Count pins are sampled once per peripheral cycle; high then low counts
    fall_a = tick && st_q.smp_a && !ca_s;
    fall_b = tick && st_q.smp_b && !cb_s;
    if (tick) begin
      st_d.smp_a = ca_s;
      st_d.smp_b = cb_s;
    end

    inc_a = advance(ctl_a, st_q.ctrl[tmr_pkg::A_RUN], xa_s, tick, fall_a);
    // Split unit A borrows the unit B run bit for its high byte
    run_b_own = st_q.ctrl[tmr_pkg::B_RUN];
    inc_b = advance(ctl_b, run_b_own, xb_s, tick, fall_b);
    // Halting unit B leaves its run bit free for the split high byte
    if (md_b == tmr_pkg::MODE_SPLIT) begin
      inc_b = 1'b0;
    end
    inc_ah = (md_a == tmr_pkg::MODE_SPLIT) && tick && run_b_own;

    // Split high byte has its own adder; step() only moves the low byte there
    nx_a   = step(md_a, inc_a, st_q.a_lo, st_q.a_hi);
    nx_b   = step(md_b, inc_b, st_q.b_lo, st_q.b_hi);
    ah_sum = {1'b0, st_q.a_hi} + 9'h001;

    st_d.a_lo = nx_a.lo;
    st_d.a_hi = nx_a.hi;
    st_d.b_lo = nx_b.lo;
    st_d.b_hi = nx_b.hi;
    if (inc_ah) begin
      st_d.a_hi = ah_sum[7:0];
    end

    set_a = nx_a.ovf;
    set_b = nx_b.ovf || (inc_ah && ah_sum[8]);

    // External interrupt detection on synchronised pins
    // History runs in both modes so a type change finds valid history
    set_xa = st_q.prev_xa && !xa_s;
    set_xb = st_q.prev_xb && !xb_s;
    st_d.prev_xa = xa_s;
    st_d.prev_xb = xb_s;

    // Software access; count writes override counting in the same cycle
    wr_ctrl = sfr_req.wr && (sfr_req.addr == tmr_pkg::ADDR_CTRL);
    if (wr_ctrl) begin
      st_d.ctrl = sfr_req.wdata;
    end
    if (sfr_req.wr) begin
      unique case (sfr_req.addr)
        tmr_pkg::ADDR_MODE: st_d.mode = sfr_req.wdata;
        tmr_pkg::ADDR_A_LO: st_d.a_lo = sfr_req.wdata;
        tmr_pkg::ADDR_A_HI: st_d.a_hi = sfr_req.wdata;
        tmr_pkg::ADDR_B_LO: st_d.b_lo = sfr_req.wdata;
        tmr_pkg::ADDR_B_HI: st_d.b_hi = sfr_req.wdata;
        default: ;
      endcase
    end

    // Vector acknowledge clears, then hardware set wins over any clear
    // so an overflow that meets its acknowledge is never lost
    if (vector_ack.unit_b) begin
      st_d.ctrl[tmr_pkg::B_OVF] = 1'b0;
    end
    if (vector_ack.unit_a) begin
      st_d.ctrl[tmr_pkg::A_OVF] = 1'b0;
    end
    if (set_b) begin
      st_d.ctrl[tmr_pkg::B_OVF] = 1'b1;
    end
    if (set_a) begin
      st_d.ctrl[tmr_pkg::A_OVF] = 1'b1;
    end

    // Type bit uses its current value; a new type applies next cycle
    if (st_q.ctrl[tmr_pkg::XB_TYP]) begin
      if (vector_ack.ext_b) begin
        st_d.ctrl[tmr_pkg::XB_FLG] = 1'b0;
      end
      if (set_xb) begin
        st_d.ctrl[tmr_pkg::XB_FLG] = 1'b1;
      end
    end else begin
      st_d.ctrl[tmr_pkg::XB_FLG] = !xb_s;
    end

    if (st_q.ctrl[tmr_pkg::XA_TYP]) begin
      if (vector_ack.ext_a) begin
        st_d.ctrl[tmr_pkg::XA_FLG] = 1'b0;
      end
      if (set_xa) begin
        st_d.ctrl[tmr_pkg::XA_FLG] = 1'b1;
      end
    end else begin
      st_d.ctrl[tmr_pkg::XA_FLG] = !xa_s;
    end

    // Registered read; unmapped addresses return zero
    // A read in the same cycle as a write returns the old value
    if (sfr_req.rd) begin
      unique case (sfr_req.addr)
        tmr_pkg::ADDR_CTRL: st_d.rdata = st_q.ctrl;
        tmr_pkg::ADDR_MODE: st_d.rdata = st_q.mode;
        tmr_pkg::ADDR_A_LO: st_d.rdata = st_q.a_lo;
        tmr_pkg::ADDR_A_HI: st_d.rdata = st_q.a_hi;
        tmr_pkg::ADDR_B_LO: st_d.rdata = st_q.b_lo;
        tmr_pkg::ADDR_B_HI: st_d.rdata = st_q.b_hi;
        default:            st_d.rdata = tmr_pkg::RST_BYTE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Sample and edge history reset high to match idle pins
  // Reset assigns constants only, so it stays a plain synchronous clear
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q         <= '0;
      st_q.smp_a   <= 1'b1;
      st_q.smp_b   <= 1'b1;
      st_q.prev_xa <= 1'b1;
      st_q.prev_xb <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Every output is a flop of the state record; no logic after the flops
  assign sfr_rdata      = st_q.rdata;
  assign irq_req.unit_b = st_q.ctrl[tmr_pkg::B_OVF];
  assign irq_req.unit_a = st_q.ctrl[tmr_pkg::A_OVF];
  assign irq_req.ext_b  = st_q.ctrl[tmr_pkg::XB_FLG];
  assign irq_req.ext_a  = st_q.ctrl[tmr_pkg::XA_FLG];

endmodule : tmr_top
`default_nettype wire

// ### pkg/tmr_pkg.sv
// Purpose: Constants and carrier types for the dual timer/counter block.
// Assumes: Special function register bus with 8-bit address and data.
// Notes:   One peripheral cycle is PERIPH_DIV system clocks.
//
// How it works
// - Unit B overflow sets bit 7, vector clears
// - Unit A overflow sets bit 5, vector clears
// - Bits 6 and 4 run units B, A
// - Pin B event sets bit 3; edge ack clears
// - Pin A event sets bit 1; edge ack clears
// - Bit 2: B low level or falling edge
// - Bit 0: A low level or falling edge
// - Mode bit 7 gates unit B by pin
// - Mode bit 3 gates unit A by pin
// - Mode bit 6: B counts clock or pin
// - Mode bit 2: A counts clock or pin
// - Mode 00: high byte, 5-bit low prescaler
// - Mode 01: full 16-bit cascade counter
// - Mode 10: low byte reloads from high
// - Unit B mode 11 holds its count
// - Unit A mode 11 splits into two
// - Timer counts once per peripheral cycle
// - Counter samples pin per peripheral cycle
// - Reload leaves high byte untouched
// - Mode 00 ignores low byte top bits

package tmr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] ADDR_CTRL = 8'h88;
  localparam logic [7:0] ADDR_MODE = 8'h89;
  localparam logic [7:0] ADDR_A_LO = 8'h8A;
  localparam logic [7:0] ADDR_B_LO = 8'h8B;
  localparam logic [7:0] ADDR_A_HI = 8'h8C;
  localparam logic [7:0] ADDR_B_HI = 8'h8D;

  localparam logic [7:0] RST_BYTE = 8'h00;

  // Control register bit positions
  localparam int B_OVF  = 7;
  localparam int B_RUN  = 6;
  localparam int A_OVF  = 5;
  localparam int A_RUN  = 4;
  localparam int XB_FLG = 3;
  localparam int XB_TYP = 2;
  localparam int XA_FLG = 1;
  localparam int XA_TYP = 0;

  // Mode register fields: unit B uses the high nibble, unit A the low
  localparam int B_NIB = 4;
  localparam int A_NIB = 0;
  localparam int GATE  = 3;
  localparam int SRC   = 2;
  localparam int MODE  = 0;

  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_RELD  = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;

  localparam int PRESC_W = 5;

  // System clocks per peripheral cycle
  localparam int         PERIPH_DIV = 12;
  localparam logic [3:0] DIV_LAST   = 4'(PERIPH_DIV - 1);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } tmr_sfr_req_t;

  typedef struct packed {
    logic unit_b;
    logic unit_a;
    logic ext_b;
    logic ext_a;
  } tmr_evt_t;

  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic       ovf;
  } tmr_cnt_t;

endpackage : tmr_pkg
